// ==== rtl/aspm_monitor.sv ====
// single axis speed, range, direction and standstill monitor with register port
`timescale 1ns/1ps
`include "aspm_params.svh"
module aspm_monitor #(
    parameter int NUM_LIMITS = 12,
    parameter int NUM_RANGES = 2,
    parameter int NUM_STANDSTILL = 3
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [15:0] speed,
    input wire logic signed [31:0] position,
    input wire logic manual_ack,
    input wire logic [1:0] direction_start,
    input wire logic [NUM_STANDSTILL-1:0] standstill_start,
    output logic [NUM_LIMITS-1:0] speed_limit_ok,
    output logic [NUM_RANGES-1:0] speed_range_ok,
    output logic [1:0] direction_ok,
    output logic [NUM_STANDSTILL-1:0] standstill_ok
);
    import aspm_pkg::*;
    localparam int NPOS = 2 + NUM_STANDSTILL;

    // whole module state
    typedef struct packed {
        logic [3:0] ctrl;
        logic [15:0] hyst;
        logic [6:0] tol_pct;
        logic [15:0] tol_time;
        logic [15:0] tol_period;
        logic [24:0] dir_tol;
        logic [24:0] sos_tol;
        logic [NUM_LIMITS-1:0][15:0] lim;
        logic [NUM_RANGES-1:0][31:0] range;
        logic [6:0] tick_cnt;
        logic tick;
        logic [NPOS-1:0] start_prev;
        aspm_pos_e [NPOS-1:0] pst;
        logic [NPOS-1:0][31:0] pref;
        logic [31:0] rdata;
    } aspm_top_s;

    aspm_top_s s_q;
    aspm_top_s s_d;
    logic [NPOS-1:0] start_all;
    logic [NPOS-1:0] start_rise;
    logic [NPOS-1:0] pos_bad;
    logic [NPOS-1:0] pos_tracks;
    logic [NPOS-1:0] pos_ok;
    logic two_prox;
    logic [5:0] widx;
    logic [31:0] rd_word;

    assign start_all = {standstill_start, direction_start};
    assign two_prox = s_q.ctrl[`ASPM_CTRL_TWO_PROX];
    assign widx = addr[7:2];

    // speed limit monitors, one per configured upper limit
    // twelve limit monitors
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_lim
            aspm_speed_chk #(.W(16)) u_lim (
                .ref_clk(ref_clk),
                .reset(reset),
                .tick_us(s_q.tick),
                .speed(speed),
                .hi_lim(s_q.lim[gi]),
                .lo_lim(16'h0000),
                .use_lo(1'b0),
                .manual(s_q.ctrl[`ASPM_CTRL_MAN_LIM]),
                .manual_ack(manual_ack),
                .hyst(s_q.hyst),
                .tol_pct(s_q.tol_pct),
                .tol_time(s_q.tol_time),
                .tol_period(s_q.tol_period),
                .ok(speed_limit_ok[gi])
            );
        end
        // two range monitors, both limits widened
        for (gi = 0; gi < NUM_RANGES; gi++) begin : g_rng
            aspm_speed_chk #(.W(16)) u_rng (
                .ref_clk(ref_clk),
                .reset(reset),
                .tick_us(s_q.tick),
                .speed(speed),
                .hi_lim(s_q.range[gi][31:16]),
                .lo_lim(s_q.range[gi][15:0]),
                .use_lo(1'b1),
                .manual(s_q.ctrl[`ASPM_CTRL_MAN_RNG]),
                .manual_ack(manual_ack),
                .hyst(s_q.hyst),
                .tol_pct(s_q.tol_pct),
                .tol_time(s_q.tol_time),
                .tol_period(s_q.tol_period),
                .ok(speed_range_ok[gi])
            );
        end
    endgenerate

    // position checks against each captured reference
    always_comb begin
        logic signed [32:0] diff;
        diff = '0;
        pos_bad = '0;
        pos_tracks = '0;
        for (int i = 0; i < NPOS; i++) begin
            diff = 33'(position) - 33'($signed(s_q.pref[i]));
            if (i == 0) begin
                // direction zero forbids the configured opposite of its sense
                if (s_q.ctrl[`ASPM_CTRL_DIR_NEG]) begin
                    pos_bad[i] = diff > 33'($signed({7'h00, s_q.dir_tol}));
                    pos_tracks[i] = diff < 33'sd0;
                end else begin
                    pos_bad[i] = -diff > 33'($signed({7'h00, s_q.dir_tol}));
                    pos_tracks[i] = diff > 33'sd0;
                end
            end else if (i == 1) begin
                // second instance watches the other permitted direction
                if (s_q.ctrl[`ASPM_CTRL_DIR_NEG]) begin
                    pos_bad[i] = -diff > 33'($signed({7'h00, s_q.dir_tol}));
                    pos_tracks[i] = diff > 33'sd0;
                end else begin
                    pos_bad[i] = diff > 33'($signed({7'h00, s_q.dir_tol}));
                    pos_tracks[i] = diff < 33'sd0;
                end
            end else begin
                pos_bad[i] = (diff > 33'($signed({7'h00, s_q.sos_tol})))
                    || (-diff > 33'($signed({7'h00, s_q.sos_tol})));
            end
        end
    end

    // read multiplexer
    always_comb begin
        rd_word = 32'h00000000;
        if (addr[1:0] == 2'b00) begin
            case (addr)
                `ASPM_OFF_CTRL: rd_word = {28'h0000000, s_q.ctrl};
                `ASPM_OFF_HYST: rd_word = {16'h0000, s_q.hyst};
                `ASPM_OFF_TOL_PCT: rd_word = {25'h0000000, s_q.tol_pct};
                `ASPM_OFF_TOL_TIME: rd_word = {16'h0000, s_q.tol_time};
                `ASPM_OFF_TOL_PERIOD: rd_word = {16'h0000, s_q.tol_period};
                `ASPM_OFF_DIR_TOL: rd_word = {7'h00, s_q.dir_tol};
                `ASPM_OFF_SOS_TOL: rd_word = {7'h00, s_q.sos_tol};
                `ASPM_OFF_STATUS: rd_word = 32'({standstill_ok, direction_ok, speed_range_ok, speed_limit_ok});
                default: begin
                    for (int i = 0; i < NUM_LIMITS; i++) begin
                        if (widx == 6'(`ASPM_OFF_LIM_BASE / 4 + i)) begin
                            rd_word = {16'h0000, s_q.lim[i]};
                        end
                    end
                    for (int i = 0; i < NUM_RANGES; i++) begin
                        if (widx == 6'(`ASPM_OFF_RANGE_BASE / 4 + i)) begin
                            rd_word = s_q.range[i];
                        end
                    end
                end
            endcase
        end
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        // microsecond tick for tolerance timers
        s_d.tick = 1'b0;
        s_d.tick_cnt = s_q.tick_cnt + 7'h01;
        if (s_q.tick_cnt == 7'(`ASPM_TICK_CYCLES - 1)) begin
            s_d.tick_cnt = 7'h00;
            s_d.tick = 1'b1;
        end
        // register writes
        if (wr && addr[1:0] == 2'b00) begin
            case (addr)
                `ASPM_OFF_CTRL: s_d.ctrl = wdata[3:0];
                `ASPM_OFF_HYST: s_d.hyst = wdata[15:0];
                `ASPM_OFF_TOL_PCT: s_d.tol_pct = wdata[6:0];
                `ASPM_OFF_TOL_TIME: s_d.tol_time = wdata[15:0];
                `ASPM_OFF_TOL_PERIOD: s_d.tol_period = wdata[15:0];
                // tolerance fields take write bits 24:0, not limited to ASPM_POS_TOL_MAX
                `ASPM_OFF_DIR_TOL: s_d.dir_tol = wdata[24:0];
                `ASPM_OFF_SOS_TOL: s_d.sos_tol = wdata[24:0];
                default: begin
                    for (int i = 0; i < NUM_LIMITS; i++) begin
                        if (widx == 6'(`ASPM_OFF_LIM_BASE / 4 + i)) begin
                            s_d.lim[i] = wdata[15:0];
                        end
                    end
                    for (int i = 0; i < NUM_RANGES; i++) begin
                        if (widx == 6'(`ASPM_OFF_RANGE_BASE / 4 + i)) begin
                            s_d.range[i] = wdata;
                        end
                    end
                end
            endcase
        end
        s_d.rdata = rd ? rd_word : 32'h00000000;
        // position monitor state machines
        s_d.start_prev = start_all;
        for (int i = 0; i < NPOS; i++) begin
            case (s_q.pst[i])
                POS_IDLE: begin
                end
                POS_ARMED: begin
                    if (pos_bad[i]) begin
                        s_d.pst[i] = POS_TRIPPED;
                    end else if (pos_tracks[i]) begin
                        s_d.pref[i] = position;
                    end
                end
                POS_TRIPPED: begin
                end
                default: s_d.pst[i] = POS_IDLE;
            endcase
            if (start_rise[i]) begin
                s_d.pst[i] = POS_ARMED;
                s_d.pref[i] = position;
            end
            // no position monitoring with proximity switches
            if (two_prox) begin
                s_d.pst[i] = POS_IDLE;
            end
        end
    end

    assign start_rise = start_all & ~s_q.start_prev;

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.ctrl <= `ASPM_RST_CTRL;
            s_q.hyst <= `ASPM_RST_HYST;
            s_q.tol_pct <= `ASPM_RST_TOL_PCT;
            s_q.tol_time <= `ASPM_RST_TOL_TIME;
            s_q.tol_period <= `ASPM_RST_TOL_PERIOD;
            s_q.dir_tol <= `ASPM_RST_POS_TOL;
            s_q.sos_tol <= `ASPM_RST_POS_TOL;
            s_q.lim <= {NUM_LIMITS{`ASPM_RST_LIMIT}};
            s_q.range <= {NUM_RANGES{`ASPM_RST_LIMIT, 16'h0000}};
            // start held high through reset needs a fresh edge
            s_q.start_prev <= '1;
            for (int i = 0; i < NPOS; i++) begin
                s_q.pst[i] <= POS_IDLE;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // monitor outputs come from the registered state
    always_comb begin
        for (int i = 0; i < NPOS; i++) begin
            pos_ok[i] = s_q.pst[i] == POS_ARMED;
        end
    end
    assign direction_ok = pos_ok[1:0];
    assign standstill_ok = pos_ok[NPOS-1:2];
    assign rdata = s_q.rdata;

    sequence s_start_edge(int k);
        !start_all[k] ##1 start_all[k] && !two_prox;
    endsequence

    a_start_rearm: assert property (@(posedge ref_clk) disable iff (reset)
        s_start_edge(0) |=> direction_ok[0] && s_q.pref[0] == $past(position))
        else $error("direction monitor not armed by start edge");
    a_sos_trip: assert property (@(posedge ref_clk) disable iff (reset)
        standstill_ok[0] && pos_bad[2] && !start_rise[2] |=> !standstill_ok[0])
        else $error("standstill monitor stayed active outside window");
    a_dir_hold: assert property (@(posedge ref_clk) disable iff (reset)
        direction_ok[1] && pos_bad[1] && !start_rise[1] |=> !direction_ok[1] ##1 !direction_ok[1] || $past(start_rise[1]))
        else $error("direction monitor did not trip on forbidden travel");
    a_prox_block: assert property (@(posedge ref_clk) disable iff (reset) $past(two_prox) |-> pos_ok == '0)
        else $error("position monitor active with proximity sensing");
    a_read_status: assert property (@(posedge ref_clk) disable iff (reset)
        rd && addr == `ASPM_OFF_STATUS |=> rdata[NUM_LIMITS-1:0] == $past(speed_limit_ok))
        else $error("status read does not match outputs");
    // read data stands only after a read
    a_read_idle: assert property (@(posedge ref_clk) disable iff (reset) !$past(rd) |-> rdata == 32'h00000000)
        else $error("read data present without a read strobe");

    a_dir_latch: assert property (@(posedge ref_clk) disable iff (reset)
        !direction_ok[0] && !start_rise[0] |=> !direction_ok[0])
        else $error("direction monitor armed without a start edge");
    a_dir_track: assert property (@(posedge ref_clk) disable iff (reset)
        direction_ok[0] && pos_tracks[0] && !pos_bad[0] && !start_rise[0] |=> s_q.pref[0] == $past(position))
        else $error("direction reference did not follow permitted travel");
    a_sos_rearm: assert property (@(posedge ref_clk) disable iff (reset)
        start_rise[2] && !two_prox |=> standstill_ok[0] && s_q.pref[2] == $past(position))
        else $error("standstill monitor not armed by start edge");
    a_sos_hold: assert property (@(posedge ref_clk) disable iff (reset)
        standstill_ok[0] && !pos_bad[2] && !two_prox |=> standstill_ok[0])
        else $error("standstill monitor dropped inside window");
    a_read_dir: assert property (@(posedge ref_clk) disable iff (reset)
        rd && addr == `ASPM_OFF_STATUS |=> rdata[NUM_LIMITS+NUM_RANGES+1:NUM_LIMITS+NUM_RANGES] == $past(direction_ok))
        else $error("status read does not match direction outputs");
endmodule : aspm_monitor

// ==== rtl/aspm_params.svh ====
// register offsets, field positions, reset values and timing counts of the axis monitor
`ifndef ASPM_PARAMS_SVH
`define ASPM_PARAMS_SVH
// byte offsets of the register words
`define ASPM_OFF_CTRL 8'h00
`define ASPM_OFF_HYST 8'h04
`define ASPM_OFF_TOL_PCT 8'h08
`define ASPM_OFF_TOL_TIME 8'h0c
`define ASPM_OFF_TOL_PERIOD 8'h10
`define ASPM_OFF_DIR_TOL 8'h14
`define ASPM_OFF_SOS_TOL 8'h18
`define ASPM_OFF_STATUS 8'h1c
`define ASPM_OFF_LIM_BASE 8'h40
`define ASPM_OFF_RANGE_BASE 8'h70
// control word fields
`define ASPM_CTRL_MAN_LIM 0
`define ASPM_CTRL_MAN_RNG 1
`define ASPM_CTRL_TWO_PROX 2
`define ASPM_CTRL_DIR_NEG 3
// reset values
`define ASPM_RST_CTRL 4'h0
`define ASPM_RST_HYST 16'h0000
`define ASPM_RST_TOL_PCT 7'h00
`define ASPM_RST_TOL_TIME 16'h0000
`define ASPM_RST_TOL_PERIOD 16'h0000
`define ASPM_RST_POS_TOL 25'h0000000
`define ASPM_RST_LIMIT 16'hffff
// tolerance percent divisor
`define ASPM_PCT_DIV 100
// tolerance times count in microsecond ticks
`define ASPM_CLK_PERIOD_NS 10
`define ASPM_TICK_NS 1000
`define ASPM_TICK_CYCLES (`ASPM_TICK_NS / `ASPM_CLK_PERIOD_NS)
// position tolerance must stay below this many increments; the tolerance writes are not checked against it
`define ASPM_POS_TOL_MAX 24900000
`endif

// ==== rtl/aspm_pkg.sv ====
// types shared by the axis speed and position monitor
package aspm_pkg;
    // state of one position based monitor
    typedef enum logic [2:0] {
        POS_IDLE = 3'b001,
        POS_ARMED = 3'b010,
        POS_TRIPPED = 3'b100
    } aspm_pos_e;
    // state of one speed checker
    typedef struct packed {
        logic ok;
        logic [15:0] acc;
        logic [15:0] gap;
    } aspm_chk_s;
endpackage : aspm_pkg

// ==== rtl/aspm_speed_chk.sv ====
// one speed checker: upper limit or range with tolerance and hysteresis
`timescale 1ns/1ps
`include "aspm_params.svh"
module aspm_speed_chk #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tick_us,
    input wire logic [W-1:0] speed,
    input wire logic [W-1:0] hi_lim,
    input wire logic [W-1:0] lo_lim,
    input wire logic use_lo,
    input wire logic manual,
    input wire logic manual_ack,
    input wire logic [W-1:0] hyst,
    input wire logic [6:0] tol_pct,
    input wire logic [15:0] tol_time,
    input wire logic [15:0] tol_period,
    output logic ok
);
    import aspm_pkg::*;
    aspm_chk_s s_q;
    aspm_chk_s s_d;
    logic [W+7:0] hi_x;
    logic [W+7:0] lo_x;
    logic [W:0] hi_w;
    logic [W-1:0] lo_w;
    logic over_nom;
    logic over_wide;
    logic inside_h;
    logic viol;
    logic [15:0] gap_n;

    // widened limits, nominal and widened overshoot, hysteresis window
    always_comb begin
        hi_x = (W + 8)'(hi_lim) * (W + 8)'(tol_pct);
        lo_x = (W + 8)'(lo_lim) * (W + 8)'(tol_pct);
        hi_w = (W + 1)'(hi_lim) + (W + 1)'(hi_x / (W + 8)'(`ASPM_PCT_DIV));
        lo_w = lo_lim - W'(lo_x / (W + 8)'(`ASPM_PCT_DIV));
        over_nom = (speed > hi_lim) || (use_lo && speed < lo_lim);
        over_wide = ((W + 1)'(speed) > hi_w) || (use_lo && speed < lo_w);
        inside_h = ((W + 1)'(speed) + (W + 1)'(hyst) <= (W + 1)'(hi_lim))
            && (!use_lo || (W + 1)'(speed) >= (W + 1)'(lo_lim) + (W + 1)'(hyst));
        viol = over_wide || (over_nom && s_q.acc > tol_time);
        gap_n = (s_q.gap == 16'hffff) ? s_q.gap : s_q.gap + 16'h0001;
    end

    // next state: tolerance timers and output latch
    always_comb begin
        s_d = s_q;
        if (tick_us) begin
            if (over_nom) begin
                s_d.gap = 16'h0000;
                if (s_q.acc != 16'hffff) begin
                    s_d.acc = s_q.acc + 16'h0001;
                end
            end else begin
                s_d.gap = gap_n;
                if (gap_n >= tol_period) begin
                    s_d.acc = 16'h0000;
                end
            end
        end
        if (viol) begin
            s_d.ok = 1'b0;
        end else if (!s_q.ok && inside_h && (!manual || manual_ack)) begin
            s_d.ok = 1'b1;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ok = s_q.ok;

    sequence s_held_low;
        !ok && manual && !manual_ack;
    endsequence

    a_wide_trip: assert property (@(posedge ref_clk) disable iff (reset) over_wide |=> !ok)
        else $error("widened limit overshoot left output high");
    a_manual_hold: assert property (@(posedge ref_clk) disable iff (reset) s_held_low |=> !ok)
        else $error("output released without manual acknowledge");
    // automatic release, not from the edge that still applies reset
    a_auto_release: assert property (@(posedge ref_clk) disable iff (reset)
        !reset && !ok && !viol && inside_h && !manual |=> ok)
        else $error("output not restored inside hysteresis");
    a_hyst_on: assert property (@(posedge ref_clk) disable iff (reset) $rose(ok) |-> $past(inside_h))
        else $error("output switched on outside hysteresis window");
    a_time_over: assert property (@(posedge ref_clk) disable iff (reset)
        over_nom && s_q.acc > tol_time |=> !ok)
        else $error("overshoot time beyond tolerance not flagged");
endmodule : aspm_speed_chk

// ==== verification/aspm_base_ctrl.sv ====
// base controller model that latches the monitor status lines
`timescale 1ns/1ps
module aspm_base_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [11:0] lim_ok,
    input wire logic [1:0] rng_ok,
    input wire logic [1:0] dir_ok,
    input wire logic [2:0] sos_ok,
    output logic [31:0] status_q
);
    always @(posedge ref_clk) begin
        if (reset) begin
            status_q <= 32'h0;
        end else begin
            status_q <= {13'h0, sos_ok, dir_ok, rng_ok, lim_ok};
        end
    end
endmodule : aspm_base_ctrl

// ==== verification/aspm_monitor_tb.sv ====
// self-checking bench for the axis monitor
`timescale 1ns/1ps
`include "aspm_params.svh"
module aspm_monitor_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] speed = 16'h0;
    logic signed [31:0] position = 32'sh0;
    logic manual_ack = 1'b0;
    logic [1:0] direction_start = 2'h0;
    logic [2:0] standstill_start = 3'h0;
    logic [11:0] speed_limit_ok;
    logic [1:0] speed_range_ok;
    logic [1:0] direction_ok;
    logic [2:0] standstill_ok;
    logic [31:0] base_status;
    logic [31:0] rv;
    logic [31:0] seed = 32'h053811dc;
    logic signed [31:0] p;
    int n_fail = 0;
    int n_tests = 0;
    // free running clock
    always #5 ref_clk = ~ref_clk;
    aspm_monitor uut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .speed(speed), .position(position), .manual_ack(manual_ack),
        .direction_start(direction_start), .standstill_start(standstill_start),
        .speed_limit_ok(speed_limit_ok), .speed_range_ok(speed_range_ok), .direction_ok(direction_ok),
        .standstill_ok(standstill_ok));
    aspm_base_ctrl partner (.ref_clk(ref_clk), .reset(reset), .lim_ok(speed_limit_ok),
        .rng_ok(speed_range_ok), .dir_ok(direction_ok), .sos_ok(standstill_ok), .status_q(base_status));
    // random source with fixed start
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    // limit output expected without tolerance or hysteresis
    function automatic logic exp_lim(input logic [15:0] s, input logic [15:0] lim);
        return s <= lim;
    endfunction : exp_lim
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk_bit(input logic a, input logic e);
        n_tests++;
        if (a !== e) begin
            n_fail++;
            $display("unexpected bit %b want %b at %0t", a, e, $time);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e) begin
            n_fail++;
            $display("unexpected word %h want %h at %0t", a, e, $time);
        end
    endtask : chk_word
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic set_speed(input logic [15:0] v);
        @(posedge ref_clk);
        speed <= v;
        step(4);
    endtask : set_speed
    // position changes on the clock edge
    task automatic set_pos(input logic signed [31:0] v);
        @(posedge ref_clk);
        position <= v;
        step(3);
    endtask : set_pos
    // start inputs low for one edge, then raised
    task automatic arm(input logic [1:0] d, input logic [2:0] s);
        @(posedge ref_clk);
        direction_start <= 2'h0;
        standstill_start <= 3'h0;
        @(posedge ref_clk);
        direction_start <= d;
        standstill_start <= s;
        step(3);
    endtask : arm
    task automatic print_verdict();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // watchdog cuts a hang short
    initial begin
        #500000;
        n_fail++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        step(4);
        chk_word({20'h0, speed_limit_ok}, 32'hfff);
        chk_word({30'h0, speed_range_ok}, 32'h3);
        wr_reg(`ASPM_OFF_HYST, 32'h32);
        rd_reg(`ASPM_OFF_HYST, rv);
        chk_word(rv, 32'h32);
        rd_reg(8'h3c, rv);
        chk_word(rv, 32'h0);
        wr_reg(`ASPM_OFF_LIM_BASE, 32'd1000);
        set_speed(16'd1001);
        chk_bit(speed_limit_ok[0], 1'b0);
        chk_bit(speed_limit_ok[1], 1'b1);
        chk_word({20'h0, speed_limit_ok}, 32'hffe);
        set_speed(16'd960);
        chk_bit(speed_limit_ok[0], 1'b0);
        set_speed(16'd950);
        chk_bit(speed_limit_ok[0], 1'b1);
        wr_reg(`ASPM_OFF_CTRL, 32'h1);
        set_speed(16'd1001);
        set_speed(16'd900);
        chk_bit(speed_limit_ok[0], 1'b0);
        @(posedge ref_clk);
        manual_ack <= 1'b1;
        @(posedge ref_clk);
        manual_ack <= 1'b0;
        step(3);
        chk_bit(speed_limit_ok[0], 1'b1);
        wr_reg(`ASPM_OFF_CTRL, 32'h0);
        wr_reg(`ASPM_OFF_TOL_PCT, 32'd10);
        wr_reg(`ASPM_OFF_TOL_TIME, 32'd3);
        wr_reg(`ASPM_OFF_TOL_PERIOD, 32'd2);
        set_speed(16'd1050);
        chk_bit(speed_limit_ok[0], 1'b1);
        step(600);
        chk_bit(speed_limit_ok[0], 1'b0);
        set_speed(16'd900);
        chk_bit(speed_limit_ok[0], 1'b1);
        step(400);
        set_speed(16'd1050);
        step(190);
        chk_bit(speed_limit_ok[0], 1'b1);
        set_speed(16'd1101);
        chk_bit(speed_limit_ok[0], 1'b0);
        set_speed(16'd900);
        wr_reg(`ASPM_OFF_RANGE_BASE, {16'd2000, 16'd500});
        set_speed(16'd460);
        chk_bit(speed_range_ok[0], 1'b1);
        wr_reg(`ASPM_OFF_TOL_PCT, 32'd0);
        set_speed(16'd400);
        chk_bit(speed_range_ok[0], 1'b0);
        chk_bit(speed_range_ok[1], 1'b1);
        set_speed(16'd540);
        chk_bit(speed_range_ok[0], 1'b0);
        set_speed(16'd600);
        chk_bit(speed_range_ok[0], 1'b1);
        set_speed(16'd2001);
        chk_bit(speed_range_ok[0], 1'b0);
        wr_reg(`ASPM_OFF_HYST, 32'h0);
        for (int i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            set_speed(16'd900 + {8'h0, seed[7:0]});
            chk_bit(speed_limit_ok[0], exp_lim(speed, 16'd1000));
        end
        seed = xorshift(seed);
        p = $signed({8'h0, seed[23:0]});
        set_pos(p);
        wr_reg(`ASPM_OFF_SOS_TOL, 32'd100);
        wr_reg(`ASPM_OFF_DIR_TOL, 32'd50);
        arm(2'b11, 3'b001);
        chk_word({29'h0, standstill_ok}, 32'h1);
        set_pos(p + 60);
        chk_bit(standstill_ok[0], 1'b1);
        set_pos(p + 101);
        chk_bit(standstill_ok[0], 1'b0);
        chk_bit(direction_ok[1], 1'b0);
        set_pos(p + 1000);
        chk_bit(direction_ok[0], 1'b1);
        set_pos(p + 960);
        chk_bit(direction_ok[0], 1'b1);
        set_pos(p + 940);
        chk_bit(direction_ok[0], 1'b0);
        arm(2'b01, 3'b001);
        chk_bit(standstill_ok[0], 1'b1);
        chk_bit(direction_ok[0], 1'b1);
        rd_reg(`ASPM_OFF_STATUS, rv);
        chk_word(rv, base_status);
        wr_reg(`ASPM_OFF_CTRL, 32'h4);
        arm(2'b11, 3'b111);
        chk_word({27'h0, standstill_ok, direction_ok}, 32'h0);
        print_verdict();
    end
endmodule : aspm_monitor_tb
